// ===== wdr_pkg.sv
package wdr_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_OP        = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_COUNT     = 8'h08;
  localparam logic [7:0] OFS_CLOCK     = 8'h0C;
  localparam logic [7:0] OFS_TIMER2    = 8'h10;
  localparam logic [7:0] OFS_TIMER3    = 8'h14;
  localparam logic [7:0] OFS_TIMER_AUX = 8'h18;
  localparam logic [7:0] OFS_KEYON     = 8'h1C;
  localparam logic [7:0] OFS_PULLUP    = 8'h20;
  localparam logic [7:0] OFS_PORT      = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h28;

  // ****************************************
  // Operation codes in the op register
  // ****************************************
  localparam logic [2:0] OP_OTHER     = 3'h0;
  localparam logic [2:0] OP_CLEAR     = 3'h1;
  localparam logic [2:0] OP_DIS_PREP  = 3'h2;
  localparam logic [2:0] OP_SW_RESET  = 3'h3;
  localparam logic [2:0] OP_BACKUP    = 3'h4;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int ST_ENABLE    = 0;
  localparam int ST_UNDERFLOW = 1;
  localparam int ST_WD_RESET  = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_SKIP      = 4;
  localparam int ST_SYS_RESET = 5;
  localparam int ST_BACKUP    = 6;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [15:0] WD_LOAD      = 16'hFFFF;
  localparam logic [3:0]  RST_ZERO4    = 4'h0;
  localparam logic [3:0]  RST_CLOCK    = 4'hF;
  localparam logic [3:0]  PIN_LOW_MC   = 4'h1;
  localparam int          MC_DIV       = 4;

endpackage : wdr_pkg

// ===== wdr_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module wdr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ****************************************
  // Two flip-flop synchroniser
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d ^ rst_val;
      q      <= meta_q ^ rst_val;
    end
  end

endmodule : wdr_sync2
`default_nettype wire

// ===== wdr_down_counter.sv
`timescale 1ns/1ns
`default_nettype none
module wdr_down_counter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        load,
  input  wire logic        tick,
  // Result
  output var  logic [15:0] count_q,
  output var  logic        underflow
);

  // ****************************************
  // Down counter
  // ****************************************
  assign underflow = tick && !load && (count_q == 16'h0000);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= wdr_pkg::WD_LOAD;
    end else if (load || underflow) begin
      // [RULE22] Reload on underflow
      count_q <= wdr_pkg::WD_LOAD;
    end else if (tick) begin
      // [RULE1] Count once per tick
      count_q <= count_q - 16'h0001;
    end
  end

endmodule : wdr_down_counter
`default_nettype wire

// ===== wdr_watchdog_reset.sv
// Summary of operation
// [RULE1] 16-bit counter from FFFF, one per cycle
// [RULE2] Underflow past zero sets underflow flag
// [RULE3] Second underflow unflagged sets reset, pin low
// [RULE4] Software clears within 65534 cycles
// [RULE5] Enable flag one makes expiry reset
// [RULE6] Prepare then clear disables watchdog
// [RULE7] Enable set by reset and backup
// [RULE8] Clear with flag set clears, skips
// [RULE9] Clear with flag clear, no skip
// [RULE10] Skip works while watchdog disabled
// [RULE11] Prepare alone keeps watchdog running
// [RULE12] Backup entry reinitialises flag and counter
// [RULE13] Software clears and nops before backup
// [RULE14] Five reset sources cause system reset
// [RULE15] Pin high restarts at page zero
// [RULE16] External low for one cycle minimum
// [RULE17] Software reset drives pin low
// [RULE18] Reset: latches one, ports float, pin low
// [RULE19] Reset: address zero, interrupts off
// [RULE20] Reset: control zeros, clock register ones
// [RULE21] Power-down flag marks warm start
// [RULE22] Underflow reloads counter automatically
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module wdr_watchdog_reset #(
  parameter int PORT_W = 4,
  parameter int MC_DIV = wdr_pkg::MC_DIV
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Reset pin, open drain
  input  wire logic              reset_pin_i,
  output var  logic              reset_pin_o,
  output var  logic              reset_pin_oe,
  // Detectors and wakeup
  input  wire logic              power_on_det,
  input  wire logic              voltage_drop_det,
  input  wire logic              wakeup_pin,
  // Timer output source
  input  wire logic              pwm_src,
  // System outputs
  output var  logic              sys_reset_q,
  output var  logic              restart_q,
  output var  logic [1:0]        pc_page_q,
  output var  logic [5:0]        pc_addr_q,
  output var  logic              global_irq_enable,
  output var  logic [PORT_W-1:0] port_latch_q,
  output var  logic              port_drive_q,
  output var  logic              pullup_active_q,
  output var  logic              counter_pwm_pin,
  output var  logic [3:0]        clock_control_reg,
  output var  logic [3:0]        timer2_control_reg,
  output var  logic [3:0]        timer3_control_reg,
  output var  logic [3:0]        timer_aux_control_reg
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] wd_down_counter;
  logic        wd_underflow;
  logic        wd_enable_flag;
  logic        wd_underflow_flag;
  logic        wd_reset_flag;
  logic        power_down_q;
  logic        skip_q;
  logic        prep_armed_q;
  logic        backup_q;
  logic [3:0]  keyon_q;
  logic [3:0]  pullup_q;
  logic [7:0]  div_q;
  logic        tick_q;
  logic [3:0]  drive_cnt_q;
  logic        pin_low;
  logic        por_s;
  logic        vdrop_s;
  logic        wake_s;
  logic        sys_reset_d;
  logic        wr_en;
  logic        rd_en;
  logic [2:0]  op;
  logic        op_valid;
  logic        wd_clear_skip_op;
  logic        wd_disable_prepare_op;
  logic        software_reset_op;
  logic        backup_op;
  logic        wd_expire;
  logic        sys_release;
  logic        counter_load;
  logic        pin_sync_hi;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == wdr_pkg::OFS_OP) || (a == wdr_pkg::OFS_STATUS) ||
             (a == wdr_pkg::OFS_COUNT) || (a == wdr_pkg::OFS_CLOCK) ||
             (a == wdr_pkg::OFS_TIMER2) || (a == wdr_pkg::OFS_TIMER3) ||
             (a == wdr_pkg::OFS_TIMER_AUX) || (a == wdr_pkg::OFS_KEYON) ||
             (a == wdr_pkg::OFS_PULLUP) || (a == wdr_pkg::OFS_PORT) ||
             (a == wdr_pkg::OFS_IRQ_EN);
  endfunction : mapped

  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction : wr_hit

  // ****************************************
  // Input synchronisers
  // ****************************************
  wdr_sync2 #(.W(4)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .d       ({reset_pin_i, power_on_det, voltage_drop_det, wakeup_pin}),
    .rst_val (4'b1000),
    .q       ({pin_sync_hi, por_s, vdrop_s, wake_s})
  );

  assign pin_low = !pin_sync_hi;

  // ****************************************
  // Machine cycle divider
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == 8'(MC_DIV - 1)) begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // ****************************************
  // APB access
  // ****************************************
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign rd_en = psel && penable && !pready;
  assign op    = pwdata[2:0];
  assign op_valid = wr_hit(wr_en, paddr, wdr_pkg::OFS_OP) && !sys_reset_q && !backup_q;

  assign wd_clear_skip_op      = op_valid && (op == wdr_pkg::OP_CLEAR);
  assign wd_disable_prepare_op = op_valid && (op == wdr_pkg::OP_DIS_PREP);
  assign software_reset_op     = op_valid && (op == wdr_pkg::OP_SW_RESET);
  assign backup_op             = op_valid && (op == wdr_pkg::OP_BACKUP);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !mapped(paddr);
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        wdr_pkg::OFS_STATUS: begin
          prdata <= {25'h000_0000, backup_q, sys_reset_q, skip_q, power_down_q,
                     wd_reset_flag, wd_underflow_flag, wd_enable_flag};
        end
        wdr_pkg::OFS_COUNT:     prdata <= {16'h0000, wd_down_counter};
        wdr_pkg::OFS_CLOCK:     prdata <= {28'h000_0000, clock_control_reg};
        wdr_pkg::OFS_TIMER2:    prdata <= {28'h000_0000, timer2_control_reg};
        wdr_pkg::OFS_TIMER3:    prdata <= {28'h000_0000, timer3_control_reg};
        wdr_pkg::OFS_TIMER_AUX: prdata <= {28'h000_0000, timer_aux_control_reg};
        wdr_pkg::OFS_KEYON:     prdata <= {28'h000_0000, keyon_q};
        wdr_pkg::OFS_PULLUP:    prdata <= {28'h000_0000, pullup_q};
        wdr_pkg::OFS_PORT:      prdata <= 32'(port_latch_q);
        wdr_pkg::OFS_IRQ_EN:    prdata <= {31'h0000_0000, global_irq_enable};
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Watchdog counter
  // ****************************************
  // [RULE12] Backup reinitialises counter
  assign counter_load = sys_reset_q || backup_q || backup_op;

  // [RULE1] Count from machine cycle
  wdr_down_counter u_counter (
    .clk       (clk),
    .rst       (rst),
    .load      (counter_load),
    .tick      (tick_q),
    .count_q   (wd_down_counter),
    .underflow (wd_underflow)
  );

  // ****************************************
  // Watchdog flags
  // ****************************************
  // [RULE3] Expiry on second underflow
  // [RULE5] Only while enabled
  assign wd_expire = wd_underflow && wd_underflow_flag && wd_enable_flag &&
                     !wd_clear_skip_op;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_underflow_flag <= 1'b0;
    end else if (sys_reset_q || backup_q || backup_op) begin
      // [RULE12] Backup clears flag
      wd_underflow_flag <= 1'b0;
    end else if (wd_underflow) begin
      // [RULE2] Underflow sets flag
      wd_underflow_flag <= 1'b1;
    end else if (wd_clear_skip_op) begin
      // [RULE8] Clear flag
      wd_underflow_flag <= 1'b0;
    end
  end

  // [RULE8] Skip when flag set
  // [RULE9] No skip when clear
  // [RULE10] Independent of enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else if (sys_reset_q) begin
      skip_q <= 1'b0;
    end else if (wd_clear_skip_op) begin
      skip_q <= wd_underflow_flag;
    end
  end

  // [RULE11] Armed only for next op
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prep_armed_q <= 1'b0;
    end else if (sys_reset_q) begin
      prep_armed_q <= 1'b0;
    end else if (op_valid) begin
      prep_armed_q <= wd_disable_prepare_op;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_enable_flag <= 1'b1;
    end else if (sys_reset_q || backup_q || backup_op) begin
      // [RULE7] Enable on reset and backup
      wd_enable_flag <= 1'b1;
    end else if (wd_clear_skip_op && prep_armed_q) begin
      // [RULE6] Prepare then clear disables
      wd_enable_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_reset_flag <= 1'b0;
    end else if (wd_expire) begin
      // [RULE3] Reset flag on expiry
      wd_reset_flag <= 1'b1;
    end else if (por_s) begin
      wd_reset_flag <= 1'b0;
    end else if (wr_hit(wr_en, paddr, wdr_pkg::OFS_STATUS) &&
                 pwdata[wdr_pkg::ST_WD_RESET]) begin
      wd_reset_flag <= 1'b0;
    end
  end

  // ****************************************
  // Reset pin drive
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_cnt_q <= 4'h0;
    end else if (wd_expire || software_reset_op) begin
      // [RULE17] Software reset drives pin
      // [RULE3] Expiry drives pin
      drive_cnt_q <= wdr_pkg::PIN_LOW_MC;
    end else if (tick_q && drive_cnt_q != 4'h0) begin
      drive_cnt_q <= drive_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_oe <= 1'b0;
      reset_pin_o  <= 1'b0;
    end else begin
      reset_pin_oe <= (wd_expire || software_reset_op || drive_cnt_q != 4'h0);
      reset_pin_o  <= 1'b0;
    end
  end

  // ****************************************
  // System reset collection
  // ****************************************
  // [RULE14] Five reset sources
  assign sys_reset_d = pin_low || software_reset_op || wd_expire || por_s ||
                       vdrop_s || reset_pin_oe || drive_cnt_q != 4'h0;
  assign sys_release = sys_reset_q && !sys_reset_d;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_reset_q <= 1'b1;
    end else begin
      sys_reset_q <= sys_reset_d;
    end
  end

  // ****************************************
  // Backup mode and restart
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backup_q <= 1'b0;
    end else if (sys_reset_q) begin
      backup_q <= 1'b0;
    end else if (backup_op) begin
      backup_q <= 1'b1;
    end else if (wake_s) begin
      backup_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_down_q <= 1'b0;
    end else if (sys_reset_q) begin
      // [RULE21] Cold reset clears flag
      power_down_q <= 1'b0;
    end else if (backup_q && wake_s) begin
      // [RULE21] Warm start sets flag
      power_down_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restart_q <= 1'b0;
      pc_page_q <= 2'h0;
      pc_addr_q <= 6'h00;
    end else begin
      // [RULE15] Restart at page zero
      // [RULE19] Program counter zeroed
      restart_q <= sys_release || (backup_q && wake_s && !sys_reset_q);
      if (sys_reset_q || backup_q) begin
        pc_page_q <= 2'h0;
        pc_addr_q <= 6'h00;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_irq_enable <= 1'b0;
    end else if (sys_reset_q || backup_q) begin
      // [RULE19] Interrupts disabled
      global_irq_enable <= 1'b0;
    end else if (wr_hit(wr_en, paddr, wdr_pkg::OFS_IRQ_EN)) begin
      global_irq_enable <= pwdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_control_reg  <= wdr_pkg::RST_CLOCK;
      timer3_control_reg <= wdr_pkg::RST_ZERO4;
    end else if (sys_reset_q || backup_q) begin
      // [RULE20] Clock ones, timer3 stopped
      clock_control_reg  <= wdr_pkg::RST_CLOCK;
      timer3_control_reg <= wdr_pkg::RST_ZERO4;
    end else begin
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_CLOCK)) begin
        clock_control_reg <= pwdata[3:0];
      end
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_TIMER3)) begin
        timer3_control_reg <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer2_control_reg    <= wdr_pkg::RST_ZERO4;
      timer_aux_control_reg <= wdr_pkg::RST_ZERO4;
      keyon_q               <= wdr_pkg::RST_ZERO4;
      pullup_q              <= wdr_pkg::RST_ZERO4;
    end else if (sys_reset_q) begin
      // [RULE20] Control registers zeroed
      timer2_control_reg    <= wdr_pkg::RST_ZERO4;
      timer_aux_control_reg <= wdr_pkg::RST_ZERO4;
      keyon_q               <= wdr_pkg::RST_ZERO4;
      pullup_q              <= wdr_pkg::RST_ZERO4;
    end else begin
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_TIMER2)) begin
        timer2_control_reg <= pwdata[3:0];
      end
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_TIMER_AUX)) begin
        timer_aux_control_reg <= pwdata[3:0];
      end
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_KEYON)) begin
        keyon_q <= pwdata[3:0];
      end
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_PULLUP)) begin
        pullup_q <= pwdata[3:0];
      end
    end
  end

  // ****************************************
  // Port state
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_latch_q    <= '1;
      port_drive_q    <= 1'b0;
      pullup_active_q <= 1'b0;
      counter_pwm_pin <= 1'b0;
    end else if (sys_reset_q) begin
      // [RULE18] Latches one, ports float
      port_latch_q    <= '1;
      port_drive_q    <= 1'b0;
      pullup_active_q <= 1'b0;
      counter_pwm_pin <= 1'b0;
    end else begin
      if (wr_hit(wr_en, paddr, wdr_pkg::OFS_PORT)) begin
        port_latch_q <= pwdata[PORT_W-1:0];
        port_drive_q <= 1'b1;
      end
      pullup_active_q <= |pullup_q;
      // [RULE18] Pin low in backup
      counter_pwm_pin <= pwm_src && !backup_q;
    end
  end

endmodule : wdr_watchdog_reset
`default_nettype wire

// ===== wdr_watchdog_reset_sva.sv
`timescale 1ns/1ns
`default_nettype none
module wdr_watchdog_reset_sva #(
  parameter int PORT_W = 4
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  // Pins and detectors
  input wire logic              reset_pin_i,
  input wire logic              reset_pin_o,
  input wire logic              reset_pin_oe,
  input wire logic              power_on_det,
  input wire logic              voltage_drop_det,
  // System
  input wire logic              sys_reset_q,
  input wire logic              restart_q,
  input wire logic [1:0]        pc_page_q,
  input wire logic [5:0]        pc_addr_q,
  input wire logic              global_irq_enable,
  input wire logic [PORT_W-1:0] port_latch_q,
  input wire logic              port_drive_q,
  input wire logic [3:0]        clock_control_reg
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_held;
    sys_reset_q [*2];
  endsequence
  property p_ready_wait;
    s_acc |=> pready;
  endproperty
  property p_unmapped;
    psel && penable && pready && !pwrite && paddr > 8'h28 |-> pslverr && prdata == '0;
  endproperty
  property p_pin_drive;
    reset_pin_oe |-> !reset_pin_o ##[0:4] sys_reset_q;
  endproperty
  property p_ext_pin;
    !reset_pin_i |-> ##[1:4] sys_reset_q;
  endproperty
  property p_detect;
    power_on_det || voltage_drop_det |-> ##[1:4] sys_reset_q;
  endproperty
  property p_reset_state;
    s_held |-> pc_page_q == '0 && pc_addr_q == '0 && !global_irq_enable
      && port_latch_q == '1 && !port_drive_q && clock_control_reg == 4'hF;
  endproperty
  property p_restart;
    $fell(sys_reset_q) |-> ##[0:2] (restart_q && pc_page_q == '0 && pc_addr_q == '0);
  endproperty
  property p_restart_pulse;
    restart_q |=> !restart_q;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong");
  a_ext_pin: assert property (p_ext_pin) else $error("pin low no reset");
  a_detect: assert property (p_detect) else $error("detector no reset");
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  a_restart: assert property (p_restart) else $error("no restart at zero");
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
endmodule : wdr_watchdog_reset_sva
bind wdr_watchdog_reset wdr_watchdog_reset_sva #(.PORT_W(PORT_W)) i_wdr_watchdog_reset_sva (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata,
  .reset_pin_i, .reset_pin_o, .reset_pin_oe, .power_on_det, .voltage_drop_det,
  .sys_reset_q, .restart_q, .pc_page_q, .pc_addr_q, .global_irq_enable,
  .port_latch_q, .port_drive_q, .clock_control_reg);
`default_nettype wire

// ===== wdr_watchdog_reset_bench.sv
`timescale 1ns/1ns
`default_nettype none
module wdr_watchdog_reset_bench;
  // ****************
  // Signals
  // ****************
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, view;
  logic        ext_low, reset_pin_i, reset_pin_o, reset_pin_oe;
  logic        power_on_det, voltage_drop_det, wakeup_pin, pwm_src;
  logic        sys_reset_q, restart_q, global_irq_enable, port_drive_q;
  logic        pullup_active_q, counter_pwm_pin;
  logic [1:0]  pc_page_q;
  logic [5:0]  pc_addr_q;
  logic [3:0]  port_latch_q, clock_control_reg, tmr2, tmr3, tmra;
  logic [15:0] c1;
  int          err_total, num_checks, n_oe, n_rst, n_rs, n, m;
  localparam logic [31:0] RST_VIEW = {9'h000, 4'hF, 3'h0, wdr_pkg::RST_CLOCK,
                                      {3{wdr_pkg::RST_ZERO4}}};
  // Pin with pull-up, pulled low by either party
  assign reset_pin_i = ~ext_low & ~(reset_pin_oe & ~reset_pin_o);
  assign view = {pc_page_q, pc_addr_q, global_irq_enable, port_latch_q, port_drive_q,
                 pullup_active_q, counter_pwm_pin, clock_control_reg, tmr2, tmr3, tmra};
  wdr_watchdog_reset #(.PORT_W(4), .MC_DIV(1)) i_wdr_watchdog_reset (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .power_on_det,
    .voltage_drop_det, .wakeup_pin, .pwm_src, .sys_reset_q, .restart_q,
    .pc_page_q, .pc_addr_q, .global_irq_enable, .port_latch_q, .port_drive_q,
    .pullup_active_q, .counter_pwm_pin, .clock_control_reg,
    .timer2_control_reg(tmr2), .timer3_control_reg(tmr3), .timer_aux_control_reg(tmra));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reset_pin_oe === 1'b1) n_oe++;
    if (sys_reset_q === 1'b1) n_rst++;
    if (restart_q === 1'b1) n_rs++;
  end
  // ****************
  // Tasks
  // ****************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      err_total++;
      end_sim();
    end
    rv = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input logic [2:0] c);
    apb(1'b1, wdr_pkg::OFS_OP, {29'h0, c});
  endtask : op
  task automatic stb(input string nm, input int b, input logic e);
    apb(1'b0, wdr_pkg::OFS_STATUS, '0);
    chk(nm, 32'(rv[b]), 32'(e));
  endtask : stb
  task automatic wait_sys(input logic v);
    int k;
    k = 0;
    while (sys_reset_q !== v && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (sys_reset_q !== v) begin
      err_total++;
      end_sim();
    end
  endtask : wait_sys
  // ****************
  // Sequence
  // ****************
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
    {ext_low, power_on_det, voltage_drop_det, wakeup_pin, pwm_src} = 5'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_sys(1'b0);
    chk("reset_view", view, RST_VIEW);
    stb("enable", wdr_pkg::ST_ENABLE, 1'b1);
    stb("powerdown", wdr_pkg::ST_POWERDOWN, 1'b0);
    apb(1'b0, wdr_pkg::OFS_KEYON, '0);
    chk("keyon", rv, '0);
    apb(1'b0, 8'h2C, '0);
    chk("unmapped", {rv[30:0], rerr}, 32'h0000_0001);
    apb(1'b0, wdr_pkg::OFS_COUNT, '0);
    c1 = rv[15:0];
    apb(1'b0, wdr_pkg::OFS_COUNT, '0);
    chk("count_down", 32'(rv[15:0] < c1), 32'h0000_0001);
    op(wdr_pkg::OP_CLEAR);
    stb("no_skip", wdr_pkg::ST_SKIP, 1'b0);
    op(wdr_pkg::OP_DIS_PREP);
    op(wdr_pkg::OP_OTHER);
    op(wdr_pkg::OP_CLEAR);
    stb("enable", wdr_pkg::ST_ENABLE, 1'b1);
    op(wdr_pkg::OP_DIS_PREP);
    op(wdr_pkg::OP_CLEAR);
    stb("enable", wdr_pkg::ST_ENABLE, 1'b0);
    for (int i = 0; i < 300 && rv[wdr_pkg::ST_UNDERFLOW] !== 1'b1; i++) begin
      repeat (256) @(posedge clk);
      apb(1'b0, wdr_pkg::OFS_STATUS, '0);
    end
    stb("underflow", wdr_pkg::ST_UNDERFLOW, 1'b1);
    apb(1'b0, wdr_pkg::OFS_COUNT, '0);
    chk("reload", 32'(rv[15:0] > 16'hFE00), 32'h0000_0001);
    op(wdr_pkg::OP_CLEAR);
    stb("skip", wdr_pkg::ST_SKIP, 1'b1);
    stb("underflow", wdr_pkg::ST_UNDERFLOW, 1'b0);
    apb(1'b1, wdr_pkg::OFS_PULLUP, 32'h0000_000F);
    apb(1'b1, wdr_pkg::OFS_PORT, '0);
    apb(1'b1, wdr_pkg::OFS_CLOCK, '0);
    chk("drive", 32'({pullup_active_q, port_drive_q}), 32'h0000_0003);
    n = n_oe;
    m = n_rs;
    op(wdr_pkg::OP_SW_RESET);
    wait_sys(1'b1);
    wait_sys(1'b0);
    repeat (3) @(posedge clk);
    chk("pin_drive", 32'(n_oe > n), 32'h0000_0001);
    chk("restart", 32'(n_rs > m), 32'h0000_0001);
    chk("reset_view", view, RST_VIEW);
    stb("enable", wdr_pkg::ST_ENABLE, 1'b1);
    for (int s = 0; s < 3; s++) begin
      n = n_rst;
      m = n_rs;
      ext_low          <= (s == 0);
      power_on_det     <= (s == 1);
      voltage_drop_det <= (s == 2);
      @(posedge clk);
      {ext_low, power_on_det, voltage_drop_det} <= 3'h0;
      repeat (4) @(posedge clk);
      wait_sys(1'b0);
      repeat (3) @(posedge clk);
      chk("src_reset", 32'(n_rst > n), 32'h0000_0001);
      chk("src_restart", 32'(n_rs > m), 32'h0000_0001);
    end
    op(wdr_pkg::OP_CLEAR);
    op(wdr_pkg::OP_OTHER);
    op(wdr_pkg::OP_BACKUP);
    pwm_src <= 1'b1;
    apb(1'b0, wdr_pkg::OFS_COUNT, '0);
    chk("count_init", rv, 32'(wdr_pkg::WD_LOAD));
    chk("pwm_backup", 32'(counter_pwm_pin), '0);
    m = n_rs;
    wakeup_pin <= 1'b1;
    repeat (4) @(posedge clk);
    wakeup_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk("wake", 32'({n_rs > m, counter_pwm_pin}), 32'h0000_0003);
    stb("powerdown", wdr_pkg::ST_POWERDOWN, 1'b1);
    stb("enable", wdr_pkg::ST_ENABLE, 1'b1);
    end_sim();
  end
endmodule : wdr_watchdog_reset_bench
`default_nettype wire
